/* pkg/wcnv_pkg.sv */
// Constants and types shared by the wiper command and storage block
package wcnv_pkg;
    // Bus and value widths
    localparam int WB_AW = 4;
    localparam int WB_DW = 32;
    localparam int WIPER_W = 8;
    // Wishbone register byte offsets
    localparam logic [3:0] OFS_WIPER = 4'h0;
    localparam logic [3:0] OFS_STORED = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_CONFIG = 4'hc;
    // Status register field positions
    localparam int ST_INIT_DONE = 0;
    localparam int ST_STANDBY = 1;
    localparam int ST_LAST_CMD = 4;
    // Config register field: factory address bits in the low two bits
    localparam logic [1:0] CFG_FACTORY_RST = 2'h0;
    // Slave address: fixed upper nibble
    localparam logic [3:0] ADDR_FIXED = 4'h5;
    // Control byte layout
    localparam int CTRL_MSB = 7;
    localparam int CTRL_XFER = 6;
    localparam int CTRL_NV_SEL = 5;
    localparam int CTRL_V_SEL = 4;
    localparam logic [3:0] CTRL_LOW_NIBBLE = 4'h1;
    // Flag triples: transfer, nonvolatile select, volatile select
    localparam logic [2:0] CODE_WR_VOL = 3'h1;
    localparam logic [2:0] CODE_WR_NV = 3'h2;
    localparam logic [2:0] CODE_RECALL = 3'h6;
    localparam logic [2:0] CODE_SAVE = 3'h5;
    // Values stored at factory and after reset
    localparam logic [7:0] NV_MIDSCALE = 8'h80;
    localparam logic [7:0] WIPER_RST = 8'h00;
    // Bits in a byte, ninth is the acknowledge clock
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Power-up load time in ns and the clock period in ns
    localparam int INIT_TIME_NS = 10000;
    localparam int CLK_PERIOD_NS = 40;
    // Longest time rounds down to whole cycles
    localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;
    // Decoded command kinds
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_WR_VOL = 3'b001,
        CMD_WR_NV = 3'b010,
        CMD_RECALL = 3'b011,
        CMD_SAVE = 3'b100
    } wcnv_cmd_type;
    // Frame phases of the serial receiver
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_CTRL = 3'b010,
        PH_DATA = 3'b011,
        PH_IGNORE = 3'b100
    } wcnv_phase_type;
endpackage : wcnv_pkg

/* rtl/wcnv_nv_store.sv */
// Nonvolatile wiper store model, kept apart from the power-on reset
`timescale 1ns/1ps
module wcnv_nv_store #(
    parameter logic [7:0] FACTORY_VAL = wcnv_pkg::NV_MIDSCALE
) (
    input wire logic clk,
    input wire logic factory_rst_n,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    // Stored value; the power-on reset does not reach it, so it
    // survives every device power cycle
    logic [7:0] cell_q;

    always_ff @(posedge clk or negedge factory_rst_n) begin
        if (!factory_rst_n) begin
            cell_q <= FACTORY_VAL;
        end else if (wr_en) begin
            cell_q <= wr_data;
        end
    end

    // Read port straight from the flip-flops
    assign rd_data = cell_q;
endmodule : wcnv_nv_store

/* rtl/wcnv_sync.sv */
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module wcnv_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_q;

    // Both stages take a constant under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : wcnv_sync

/* rtl/wcnv_top.sv */
// Serial command decoder and wiper storage with a Wishbone view
`timescale 1ns/1ps

// Overview of operation
// - write-volatile stores data, moves wiper
// - write-nonvolatile touches stored register only
// - recall copies stored into wiper
// - save copies wiper into stored
// - control byte: 0, flags, low nibble 0001
// - address, control, data bytes; ack; stop
// - stored register holds one persistent byte
// - stored value starts at midscale
// - power-up loads stored value into wiper
// - power-up load completes within 10 us
// - standby pin after power-up load, whenever no transaction runs; the status bit shows an idle frame even during the load
// - slave address begins 0101, factory bits
// - lowest address bit follows select pin
// - device drives ack low, ninth clock
module wcnv_top #(
    parameter int INIT_CYCLES = wcnv_pkg::INIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic factory_nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic address_select_pin,
    output logic [7:0] wiper_tap,
    output logic wiper_valid,
    output logic standby,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // Complete state of the block
    typedef struct packed {
        wcnv_pkg::wcnv_phase_type phase; // Frame phase
        logic [3:0] bit_cnt;             // Bits taken in current byte
        logic [7:0] shift;               // Incoming byte, MSB first
        logic in_ack;                    // Inside the ninth clock
        logic ack_drive;                 // Pulling the data line low
        logic [7:0] ctrl;                // Control byte of the frame
        logic [7:0] data;                // Data byte of the frame
        logic data_ok;                   // Data byte acknowledged
        logic scl_prev;                  // Last synced clock level
        logic sda_prev;                  // Last synced data level
        logic [7:0] vol;                 // Volatile wiper register
        logic [15:0] init_cnt;           // Power-up load timer
        logic init_done;                 // Wiper value valid
        logic [1:0] factory;             // Factory address bits
        wcnv_pkg::wcnv_cmd_type last_cmd; // Last executed command
        logic wb_ack;                    // Bus acknowledge
        logic [31:0] wb_dat;             // Bus read data
    } wcnv_state_type;

    wcnv_state_type st_q; // Registered state
    wcnv_state_type st_d; // Next state

    logic rst_n;       // Synchronised reset
    logic [2:0] pins;  // Synced clock, data and select pin
    logic scl_s;       // Synced serial clock
    logic sda_s;       // Synced serial data
    logic a_sel_s;     // Synced address select pin
    logic [7:0] nv_val; // Stored register contents
    logic nv_we;       // Stored register write strobe
    logic [7:0] nv_wdata; // Stored register write value

    // Reset release through two flip-flops
    wcnv_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk(ref_clk),
        .rst_n(nrst),
        .d(1'b1),
        .q(rst_n)
    );

    // Pins come from the master's domain, so they pass two stages
    wcnv_sync #(.WIDTH(3), .RST_VAL(3'b011)) u_pin_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .d({address_select_pin, scl_i, sda_i}),
        .q(pins)
    );

    assign a_sel_s = pins[2];
    assign scl_s = pins[1];
    assign sda_s = pins[0];

    // Nonvolatile store, reset only by the factory line
    wcnv_nv_store u_nv (
        .clk(ref_clk),
        .factory_rst_n(factory_nrst),
        .wr_en(nv_we),
        .wr_data(nv_wdata),
        .rd_data(nv_val)
    );

    function automatic wcnv_pkg::wcnv_cmd_type decode_ctrl(
        input logic [7:0] c
    );
        logic [2:0] flags;
        flags = {c[wcnv_pkg::CTRL_XFER], c[wcnv_pkg::CTRL_NV_SEL],
                 c[wcnv_pkg::CTRL_V_SEL]};
        decode_ctrl = wcnv_pkg::CMD_NONE;
        if (!c[wcnv_pkg::CTRL_MSB] &&
            c[3:0] == wcnv_pkg::CTRL_LOW_NIBBLE) begin
            case (flags)
                wcnv_pkg::CODE_WR_VOL: decode_ctrl = wcnv_pkg::CMD_WR_VOL;
                wcnv_pkg::CODE_WR_NV: decode_ctrl = wcnv_pkg::CMD_WR_NV;
                wcnv_pkg::CODE_RECALL: decode_ctrl = wcnv_pkg::CMD_RECALL;
                wcnv_pkg::CODE_SAVE: decode_ctrl = wcnv_pkg::CMD_SAVE;
                default: decode_ctrl = wcnv_pkg::CMD_NONE;
            endcase
        end
    endfunction : decode_ctrl

    // Whole next-state computation
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic exec;
        logic addr_hit;
        logic wb_req;
        wcnv_pkg::wcnv_cmd_type cmd;
        st_d = st_q;
        nv_we = 1'b0;
        nv_wdata = st_q.data;
        scl_rise = scl_s && !st_q.scl_prev;
        scl_fall = !scl_s && st_q.scl_prev;
        // Start and stop are data edges while the clock stays high
        start_c = scl_s && st_q.scl_prev && st_q.sda_prev && !sda_s;
        stop_c = scl_s && st_q.scl_prev && !st_q.sda_prev && sda_s;
        cmd = decode_ctrl(st_q.ctrl);
        exec = 1'b0;
        addr_hit = st_q.shift[7:1] ==
                   {wcnv_pkg::ADDR_FIXED, st_q.factory, a_sel_s};
        wb_req = wb_cyc_i && wb_stb_i && !st_q.wb_ack;
        st_d.scl_prev = scl_s;
        st_d.sda_prev = sda_s;

        if (!st_q.init_done) begin
            if (st_q.init_cnt >= 16'(INIT_CYCLES - 1)) begin
                st_d.vol = nv_val;
                st_d.init_done = 1'b1;
            end else begin
                st_d.init_cnt = st_q.init_cnt + 16'h0001;
            end
        end

        // Frame control: start wins over bit activity
        if (start_c) begin
            // Repeated start also restarts the frame
            st_d.phase = st_q.init_done ? wcnv_pkg::PH_ADDR
                                        : wcnv_pkg::PH_IDLE;
            st_d.bit_cnt = 4'h0;
            st_d.in_ack = 1'b0;
            st_d.ack_drive = 1'b0;
            st_d.data_ok = 1'b0;
        end else if (stop_c) begin
            exec = st_q.data_ok;
            st_d.phase = wcnv_pkg::PH_IDLE;
            st_d.bit_cnt = 4'h0;
            st_d.in_ack = 1'b0;
            st_d.ack_drive = 1'b0;
            st_d.data_ok = 1'b0;
        end else if (st_q.phase != wcnv_pkg::PH_IDLE) begin
            if (scl_rise && st_q.bit_cnt < wcnv_pkg::BITS_PER_BYTE) begin
                // Data is stable while the clock is high
                st_d.shift = {st_q.shift[6:0], sda_s};
                st_d.bit_cnt = st_q.bit_cnt + 4'h1;
            end else if (scl_fall && st_q.in_ack) begin
                // End of the ninth clock: release the line
                st_d.in_ack = 1'b0;
                st_d.ack_drive = 1'b0;
                st_d.bit_cnt = 4'h0;
            end else if (scl_fall &&
                         st_q.bit_cnt == wcnv_pkg::BITS_PER_BYTE) begin
                st_d.in_ack = 1'b1;
                case (st_q.phase)
                    wcnv_pkg::PH_ADDR: begin
                        if (addr_hit && !st_q.shift[0]) begin
                            st_d.ack_drive = 1'b1;
                            st_d.phase = wcnv_pkg::PH_CTRL;
                        end else begin
                            st_d.phase = wcnv_pkg::PH_IGNORE;
                        end
                    end
                    wcnv_pkg::PH_CTRL: begin
                        st_d.ack_drive = 1'b1;
                        st_d.ctrl = st_q.shift;
                        st_d.phase = wcnv_pkg::PH_DATA;
                    end
                    wcnv_pkg::PH_DATA: begin
                        st_d.ack_drive = 1'b1;
                        st_d.data = st_q.shift;
                        st_d.data_ok = 1'b1;
                        st_d.phase = wcnv_pkg::PH_IGNORE;
                    end
                    default: begin
                        // Surplus bytes are left unacknowledged
                        st_d.phase = wcnv_pkg::PH_IGNORE;
                    end
                endcase
            end
        end

        // Command execution at the stop of a complete frame
        if (exec) begin
            st_d.last_cmd = cmd;
            case (cmd)
                wcnv_pkg::CMD_WR_VOL: begin
                    st_d.vol = st_q.data;
                end
                wcnv_pkg::CMD_WR_NV: begin
                    nv_we = 1'b1;
                    nv_wdata = st_q.data;
                end
                wcnv_pkg::CMD_RECALL: begin
                    st_d.vol = nv_val;
                end
                wcnv_pkg::CMD_SAVE: begin
                    nv_we = 1'b1;
                    nv_wdata = st_q.vol;
                end
                default: begin
                    st_d.last_cmd = wcnv_pkg::CMD_NONE;
                end
            endcase
        end

        // Wishbone slave: one wait state, ack for one cycle
        st_d.wb_ack = wb_req;
        if (wb_req) begin
            st_d.wb_dat = 32'h0000_0000;
            case (wb_adr_i)
                wcnv_pkg::OFS_WIPER: st_d.wb_dat[7:0] = st_q.vol;
                wcnv_pkg::OFS_STORED: st_d.wb_dat[7:0] = nv_val;
                wcnv_pkg::OFS_STATUS: begin
                    st_d.wb_dat[wcnv_pkg::ST_INIT_DONE] = st_q.init_done;
                    st_d.wb_dat[wcnv_pkg::ST_STANDBY] =
                        st_q.phase == wcnv_pkg::PH_IDLE;
                    st_d.wb_dat[wcnv_pkg::ST_LAST_CMD +: 3] = st_q.last_cmd;
                end
                wcnv_pkg::OFS_CONFIG: begin
                    st_d.wb_dat[1:0] = st_q.factory;
                    // Address bits change only via byte lane zero
                    if (wb_we_i && wb_sel_i[0]) begin
                        st_d.factory = wb_dat_i[1:0];
                    end
                end
                default: begin
                    // Unmapped offsets read zero and ignore writes
                    st_d.wb_dat = 32'h0000_0000;
                end
            endcase
        end
    end

    // Single state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.phase <= wcnv_pkg::PH_IDLE;
            st_q.bit_cnt <= 4'h0;
            st_q.shift <= 8'h00;
            st_q.in_ack <= 1'b0;
            st_q.ack_drive <= 1'b0;
            st_q.ctrl <= 8'h00;
            st_q.data <= 8'h00;
            st_q.data_ok <= 1'b0;
            st_q.scl_prev <= 1'b1;
            st_q.sda_prev <= 1'b1;
            st_q.vol <= wcnv_pkg::WIPER_RST;
            st_q.init_cnt <= 16'h0000;
            st_q.init_done <= 1'b0;
            st_q.factory <= wcnv_pkg::CFG_FACTORY_RST;
            st_q.last_cmd <= wcnv_pkg::CMD_NONE;
            st_q.wb_ack <= 1'b0;
            st_q.wb_dat <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
        end
    end

    // Open-drain data line: only ever pulled low
    assign sda_o = 1'b0;
    assign sda_oe = st_q.ack_drive;
    assign wiper_tap = st_q.vol;
    assign wiper_valid = st_q.init_done;
    assign standby = st_q.init_done && st_q.phase == wcnv_pkg::PH_IDLE;
    assign wb_dat_o = st_q.wb_dat;
    assign wb_ack_o = st_q.wb_ack;
endmodule : wcnv_top

/* tb/tb_wcnv_top.sv */
// Self-checking bench of the wiper command and storage block
`timescale 1ns/1ps
module tb_wcnv_top;
    localparam int INIT = 4;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic factory_nrst = 1'b0;
    logic a0_pin = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_rdata;
    logic wb_ack;
    logic scl, sda_drv, sda_line, sda_o, sda_oe, valid, standby;
    logic [7:0] wiper;
    int err_total = 0;
    int tests_run = 0;
    // Rows: control, data, expected wiper, expected stored byte
    logic [31:0] rows [10] = '{32'h113C_3C80, 32'h21A5_3CA5,
        32'h6100_A5A5, 32'h11FF_FFA5, 32'h5112_FFFF, 32'h1100_00FF,
        32'h7155_00FF, 32'h9155_00FF, 32'h1355_00FF, 32'h6100_FFFF};
    always #20 ref_clk = ~ref_clk;
    // Pull-up line: low if either party pulls it
    assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
    wcnv_top #(.INIT_CYCLES(INIT)) wcnv_top_inst (.ref_clk(ref_clk),
        .nrst(nrst), .factory_nrst(factory_nrst), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_select_pin(a0_pin), .wiper_tap(wiper),
        .wiper_valid(valid), .standby(standby), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdata),
        .wb_ack_o(wb_ack));
    wcnv_i2c_master wcnv_i2c_master_inst (.scl(scl), .sda_drv(sda_drv),
        .sda_line(sda_line));
    task automatic complete_run;
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk
    // One classic cycle; data taken at the edge that sees ack
    task automatic wb_xfer(input logic we, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_rdata;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        chk("wb_ack", 32'h1, 32'(wb_ack));
    endtask : wb_xfer
    task automatic frame(input logic [7:0] a, input logic [7:0] c,
        input logic [7:0] d, output logic [2:0] nk);
        wcnv_i2c_master_inst.send_frame(a, c, d, nk);
        repeat (6) @(posedge ref_clk);
    endtask : frame
    function automatic logic [7:0] adr_b(input logic [1:0] f,
        input logic p, input logic rw);
        return {wcnv_pkg::ADDR_FIXED, f, p, rw};
    endfunction : adr_b
    // Watchdog well beyond the expected run
    initial begin
        #2_000_000;
        err_total++;
        complete_run();
    end
    initial begin
        logic [31:0] q;
        logic [2:0] nk;
        logic [7:0] c;
        repeat (5) @(posedge ref_clk);
        chk("wiper_rst", 32'h0, 32'(wiper));
        nrst <= 1'b1;
        factory_nrst <= 1'b1;
        repeat (INIT + 12) @(posedge ref_clk);
        chk("wiper_load", 32'h80, 32'(wiper));
        chk("standby", 32'h1, 32'(standby));
        wb_xfer(1'b0, wcnv_pkg::OFS_CONFIG, 32'h0, q);
        chk("config", 32'h0, q & 32'h3);
        // Command table, good and bad control bytes
        for (int i = 0; i < 10; i++) begin
            c = rows[i][31:24];
            frame(adr_b(2'h0, 1'b0, 1'b0), c, rows[i][23:16], nk);
            chk("addr_ack", 32'h0, 32'(nk[2]));
            if (c inside {8'h11, 8'h21, 8'h61, 8'h51}) begin
                chk("acks", 32'h0, 32'(nk));
            end
            chk("wiper", 32'(rows[i][15:8]), 32'(wiper));
            wb_xfer(1'b0, wcnv_pkg::OFS_STORED, 32'h0, q);
            chk("stored", 32'(rows[i][7:0]), q & 32'hff);
        end
        // Pin low, so an address with the pin bit set is refused
        frame(adr_b(2'h0, 1'b1, 1'b0), 8'h11, 8'h5A, nk);
        chk("pin_nack", 32'h7, 32'(nk));
        a0_pin <= 1'b1;
        frame(adr_b(2'h0, 1'b1, 1'b0), 8'h11, 8'h5A, nk);
        chk("pin_wiper", 32'h5A, 32'(wiper));
        frame(adr_b(2'h0, 1'b1, 1'b1), 8'h11, 8'h33, nk);
        chk("rd_nack", 32'h7, 32'(nk));
        wb_xfer(1'b1, wcnv_pkg::OFS_CONFIG, 32'h3, q);
        frame(adr_b(2'h0, 1'b1, 1'b0), 8'h11, 8'h44, nk);
        chk("old_nack", 32'h7, 32'(nk));
        // Standby must drop while a frame is on the wire
        fork
            frame(adr_b(2'h3, 1'b1, 1'b0), 8'h11, 8'h77, nk);
            begin
                repeat (40) @(posedge ref_clk);
                chk("busy", 32'h0, 32'(standby));
            end
        join
        chk("fac_wiper", 32'h77, 32'(wiper));
        // Read-only and unmapped places
        wb_xfer(1'b1, wcnv_pkg::OFS_WIPER, 32'h0, q);
        wb_xfer(1'b0, wcnv_pkg::OFS_WIPER, 32'h0, q);
        chk("wiper_ro", 32'h77, q);
        wb_xfer(1'b0, 4'h2, 32'h0, q);
        chk("unmapped", 32'h0, q);
        wb_xfer(1'b0, wcnv_pkg::OFS_STATUS, 32'h0, q);
        chk("status", 32'h13, q & 32'h7f);
        // Second reset keeps the stored byte and reloads it
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (INIT + 12) @(posedge ref_clk);
        chk("reload", 32'hFF, 32'(wiper));
        complete_run();
    end
endmodule : tb_wcnv_top

/* tb/wcnv_chk.sv */
// Port checker for the wiper command and storage block
`timescale 1ns/1ps
module wcnv_chk #(
    parameter int INIT_CYCLES = 250
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic factory_nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic address_select_pin,
    input wire logic [7:0] wiper_tap,
    input wire logic wiper_valid,
    input wire logic standby,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    // Cycles spent before the power-up load, frozen once valid
    logic [15:0] wait_q;
    logic [15:0] wait_d;
    // Count only while the wiper is not yet valid
    always_comb begin
        wait_d = wiper_valid ? wait_q : wait_q + 16'h0001;
    end
    // Cleared by power-on reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 16'h0000;
        end else begin
            wait_q <= wait_d;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("bus request not answered next cycle");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack longer than one cycle");
    property p_oe_rise;
        $rose(sda_oe) |-> !scl_i;
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("ack drive began while clock high");
    property p_oe_fall;
        $fell(sda_oe) |-> !scl_i;
    endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("ack drive ended while clock high");
    property p_drive_low;
        sda_oe |-> !sda_o;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("data line driven high");
    property p_no_early_ack;
        !wiper_valid |-> !sda_oe;
    endproperty
    a_no_early_ack: assert property (p_no_early_ack)
        else $error("ack before power-up load");
    property p_valid_keep;
        wiper_valid |=> wiper_valid;
    endproperty
    a_valid_keep: assert property (p_valid_keep)
        else $error("wiper valid dropped");
    property p_init_late;
        int'(wait_q) <= INIT_CYCLES + 6;
    endproperty
    a_init_late: assert property (p_init_late)
        else $error("power-up load too slow");
    property p_init_early;
        wiper_valid |-> int'(wait_q) >= INIT_CYCLES;
    endproperty
    a_init_early: assert property (p_init_early)
        else $error("power-up load too early");
    property p_standby;
        standby |-> wiper_valid && !sda_oe;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby during activity");
    property p_wiper_at_stop;
        $changed(wiper_tap) && $past(wiper_valid) |-> scl_i && sda_i;
    endproperty
    a_wiper_at_stop: assert property (p_wiper_at_stop)
        else $error("wiper moved outside a stop");
endmodule : wcnv_chk
bind wcnv_top wcnv_chk #(.INIT_CYCLES(INIT_CYCLES)) wcnv_chk_inst (
    .ref_clk(ref_clk), .nrst(nrst), .factory_nrst(factory_nrst),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_select_pin(address_select_pin), .wiper_tap(wiper_tap),
    .wiper_valid(wiper_valid), .standby(standby), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

/* tb/wcnv_i2c_master.sv */
// Serial bus master model that sends three-byte write frames
`timescale 1ns/1ps
module wcnv_i2c_master (
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    // Both lines rest high between frames; the clock stands still
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // byte MSB first, line released for ack
    task automatic put_byte(input logic [7:0] b, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            #80 scl = 1'b1;
            #160 scl = 1'b0;
            #80;
        end
        sda_drv = 1'b1;
        #80 scl = 1'b1;
        #80 nack = sda_line;
        #80 scl = 1'b0;
        #80;
    endtask : put_byte
    task automatic send_frame(input logic [7:0] a, input logic [7:0] c,
        input logic [7:0] d, output logic [2:0] nack);
        // Callers start on a clock edge; shift off it so that no pin
        // edge races the block's sampling edge
        #10;
        sda_drv = 1'b0;
        #160 scl = 1'b0;
        #80;
        put_byte(a, nack[2]);
        put_byte(c, nack[1]);
        put_byte(d, nack[0]);
        sda_drv = 1'b0;
        #80 scl = 1'b1;
        #160 sda_drv = 1'b1;
        #320;
    endtask : send_frame
endmodule : wcnv_i2c_master
